/* logic/pcf_pkg.sv */
// Package for the programmable CRC engine with data FIFO
// Notes on behaviour
// - Depth 8 when length field above 7, else 16
// - Entries right aligned, one byte minimum per write
// - Count increments on write of top byte
// - Shift only while started and count nonzero
// - One bit per clock, length times count cycles
// - Full at depth, empty at zero count
// - Write while full rolls count to zero, no interrupt
// - Interrupt when count goes from one to zero
// - Sleep freezes state, resumes unchanged
// - Stop-in-idle selects freeze or run in idle
// - Length field holds polynomial length minus one
// - Tap bits select terms, constant term always
`default_nettype none
package pcf_pkg;

  // ==========================================================
  // Register offsets (word index)
  localparam logic [2:0] PCF_OFS_CTRL = 3'h0;
  localparam logic [2:0] PCF_OFS_TAPS = 3'h1;
  localparam logic [2:0] PCF_OFS_RESULT = 3'h2;
  localparam logic [2:0] PCF_OFS_WDATA = 3'h3;
  localparam logic [2:0] PCF_OFS_ISTAT = 3'h4;
  localparam logic [2:0] PCF_OFS_IMASK = 3'h5;

  // ==========================================================
  // Control register field positions
  localparam int PCF_BIT_STOP_IDLE = 13;
  localparam int PCF_BIT_COUNT_LO = 8;
  localparam int PCF_BIT_FULL = 7;
  localparam int PCF_BIT_EMPTY = 6;
  localparam int PCF_BIT_GO = 4;
  localparam int PCF_BIT_IRQ_DRAIN = 0;

  // ==========================================================
  // Sizes and reset values
  localparam int PCF_DATA_W = 16;
  localparam int PCF_CNT_W = 5;
  localparam int PCF_PTR_W = 4;
  localparam logic [4:0] PCF_DEPTH_LONG = 5'h08;
  localparam logic [4:0] PCF_DEPTH_SHORT = 5'h10;
  localparam logic [3:0] PCF_LEN_SPLIT = 4'h7;
  localparam logic [15:0] PCF_TAPS_RST = 16'h0000;
  localparam logic [15:0] PCF_RESULT_RST = 16'h0000;
  localparam logic [3:0] PCF_LEN_RST = 4'h0;

  // ==========================================================
  // Control fields carried together
  typedef struct packed {
    logic stop_idle;
    logic go;
    logic [3:0] poly_len;
  } pcf_ctrl_s;

  localparam pcf_ctrl_s PCF_CTRL_RST = '{stop_idle: 1'b0, go: 1'b0, poly_len: 4'h0};

endpackage : pcf_pkg
`default_nettype wire

/* logic/pcf_crc_engine.sv */
// Programmable CRC engine with word FIFO and drain interrupt
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module pcf_crc_engine #(
  parameter int DATA_W = pcf_pkg::PCF_DATA_W,
  parameter int FIFO_MAX = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [1:0] bus_be,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  output logic irq
);

  // ==========================================================
  // State
  pcf_pkg::pcf_ctrl_s ctrl_r, ctrl_nxt;
  logic [15:0] taps_r, taps_nxt;
  logic [15:0] crc_r, crc_nxt;
  logic [15:0] stage_r, stage_nxt;
  logic [4:0] count_r, count_nxt;
  logic [3:0] wr_ptr_r, wr_ptr_nxt;
  logic [3:0] rd_ptr_r, rd_ptr_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic istat_r, istat_nxt;
  logic imask_r, imask_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [DATA_W-1:0] fifo_mem [FIFO_MAX];

  // ==========================================================
  // Derived terms
  logic [4:0] depth;
  logic full;
  logic empty;
  logic freeze;
  logic shift_en;
  logic [15:0] len_mask;
  logic [15:0] head;
  logic [3:0] cur_bit;
  logic din;
  logic fb;
  logic [15:0] push_word;
  logic wr_ctrl, wr_taps, wr_res, wr_wdat, wr_imask;
  logic msb_written;
  logic push;
  logic rollover;
  logic pop;
  logic drain_evt;

  // Short polynomials pack twice as many entries
  assign depth = (ctrl_r.poly_len > pcf_pkg::PCF_LEN_SPLIT) ?
                 pcf_pkg::PCF_DEPTH_LONG : pcf_pkg::PCF_DEPTH_SHORT;
  assign full = (count_r == depth);
  assign empty = (count_r == 5'h00);

  // Freeze holds every flip-flop of the datapath; bus and irq stay live
  assign freeze = sleep_mode | (idle_mode & ctrl_r.stop_idle);
  assign shift_en = ctrl_r.go & ~empty & ~freeze;

  assign len_mask = 16'hffff >> (4'hf - ctrl_r.poly_len);
  assign head = fifo_mem[rd_ptr_r];
  assign cur_bit = ctrl_r.poly_len - bit_cnt_r;
  assign din = head[cur_bit];
  assign fb = din ^ crc_r[ctrl_r.poly_len];

  assign wr_ctrl = bus_wr && (bus_addr == pcf_pkg::PCF_OFS_CTRL);
  assign wr_taps = bus_wr && (bus_addr == pcf_pkg::PCF_OFS_TAPS);
  assign wr_res = bus_wr && (bus_addr == pcf_pkg::PCF_OFS_RESULT);
  assign wr_wdat = bus_wr && (bus_addr == pcf_pkg::PCF_OFS_WDATA);
  assign wr_imask = bus_wr && (bus_addr == pcf_pkg::PCF_OFS_IMASK);

  // The top data bit lives in byte one only for lengths above eight
  assign msb_written = ctrl_r.poly_len[3] ? bus_be[1] : bus_be[0];
  assign push_word = {bus_be[1] ? bus_wdata[15:8] : stage_r[15:8],
                      bus_be[0] ? bus_wdata[7:0] : stage_r[7:0]} & len_mask;
  assign push = wr_wdat & msb_written & ~freeze;
  assign rollover = push & full;
  assign pop = shift_en & (bit_cnt_r == ctrl_r.poly_len) & ~rollover;
  assign drain_evt = pop & ~push & (count_r == 5'h01);

  // ==========================================================
  // Next-state logic
  always_comb begin
    ctrl_nxt = ctrl_r;
    taps_nxt = taps_r;
    crc_nxt = crc_r;
    stage_nxt = stage_r;
    count_nxt = count_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    bit_cnt_nxt = bit_cnt_r;
    istat_nxt = istat_r;
    imask_nxt = imask_r;
    rdata_nxt = 16'h0000;

    if (wr_ctrl) begin
      if (bus_be[1]) begin
        ctrl_nxt.stop_idle = bus_wdata[pcf_pkg::PCF_BIT_STOP_IDLE];
      end
      if (bus_be[0]) begin
        ctrl_nxt.go = bus_wdata[pcf_pkg::PCF_BIT_GO];
        ctrl_nxt.poly_len = bus_wdata[3:0];
      end
    end
    if (wr_taps) begin
      if (bus_be[1]) begin
        taps_nxt[15:8] = bus_wdata[15:8];
      end
      if (bus_be[0]) begin
        taps_nxt[7:1] = bus_wdata[7:1];
      end
    end
    if (wr_imask && bus_be[0]) begin
      imask_nxt = bus_wdata[pcf_pkg::PCF_BIT_IRQ_DRAIN];
    end
    if (wr_wdat && !freeze) begin
      stage_nxt = push_word;
    end

    // Seeding the result by software, shifting takes precedence
    if (wr_res && !shift_en) begin
      if (bus_be[1]) begin
        crc_nxt[15:8] = bus_wdata[15:8];
      end
      if (bus_be[0]) begin
        crc_nxt[7:0] = bus_wdata[7:0];
      end
    end

    // One data bit per clock into the LFSR
    if (shift_en && !rollover) begin
      crc_nxt = (crc_r << 1) & len_mask;
      if (fb) begin
        crc_nxt = crc_nxt ^ ({taps_r[15:1], 1'b1} & len_mask);
      end
      if (pop) begin
        bit_cnt_nxt = 4'h0;
        rd_ptr_nxt = rd_ptr_r + 4'h1;
      end else begin
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end
    end

    // Overflowing write discards the queue silently
    if (rollover) begin
      count_nxt = 5'h00;
      wr_ptr_nxt = rd_ptr_r;
      bit_cnt_nxt = 4'h0;
    end else if (push && !pop) begin
      count_nxt = count_r + 5'h01;
      wr_ptr_nxt = wr_ptr_r + 4'h1;
    end else if (pop && !push) begin
      count_nxt = count_r - 5'h01;
    end else if (push && pop) begin
      wr_ptr_nxt = wr_ptr_r + 4'h1;
    end

    // Register read path, one cycle latency
    if (bus_rd) begin
      if (bus_addr == pcf_pkg::PCF_OFS_CTRL) begin
        rdata_nxt[pcf_pkg::PCF_BIT_STOP_IDLE] = ctrl_r.stop_idle;
        rdata_nxt[12:8] = count_r;
        rdata_nxt[pcf_pkg::PCF_BIT_FULL] = full;
        rdata_nxt[pcf_pkg::PCF_BIT_EMPTY] = empty;
        rdata_nxt[pcf_pkg::PCF_BIT_GO] = ctrl_r.go;
        rdata_nxt[3:0] = ctrl_r.poly_len;
      end else if (bus_addr == pcf_pkg::PCF_OFS_TAPS) begin
        rdata_nxt = {taps_r[15:1], 1'b0};
      end else if (bus_addr == pcf_pkg::PCF_OFS_RESULT) begin
        rdata_nxt = crc_r;
      end else if (bus_addr == pcf_pkg::PCF_OFS_WDATA) begin
        rdata_nxt = crc_r;
      end else if (bus_addr == pcf_pkg::PCF_OFS_ISTAT) begin
        rdata_nxt[pcf_pkg::PCF_BIT_IRQ_DRAIN] = istat_r;
        istat_nxt = 1'b0;
      end else if (bus_addr == pcf_pkg::PCF_OFS_IMASK) begin
        rdata_nxt[pcf_pkg::PCF_BIT_IRQ_DRAIN] = imask_r;
      end else begin
        rdata_nxt = 16'h0000;
      end
    end

    // A drain in the same cycle as the clearing read is kept
    if (drain_evt) begin
      istat_nxt = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= pcf_pkg::PCF_CTRL_RST;
      taps_r <= pcf_pkg::PCF_TAPS_RST;
      crc_r <= pcf_pkg::PCF_RESULT_RST;
      stage_r <= 16'h0000;
      count_r <= 5'h00;
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      bit_cnt_r <= 4'h0;
      istat_r <= 1'b0;
      imask_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      taps_r <= taps_nxt;
      crc_r <= crc_nxt;
      stage_r <= stage_nxt;
      count_r <= count_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Storage needs no reset; count gates every read of it
  always_ff @(posedge ref_clk) begin
    if (push && !rollover) begin
      fifo_mem[wr_ptr_r] <= push_word[DATA_W-1:0];
    end
  end

  assign bus_rdata = rdata_r;
  // Level output stays live while frozen so pending events pass on
  assign irq = istat_r & imask_r;

endmodule : pcf_crc_engine

`default_nettype wire

/* dv/pcf_crc_engine_checker.sv */
// Port checker for the CRC engine
`timescale 1ns/1ps
`default_nettype none
module pcf_crc_engine_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [1:0] bus_be,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic irq
);
  // ==========
  // Shadow mask and read markers
  logic m_r, m_nxt, rc_r, rc_nxt, rt_r, rt_nxt, ri_r, ri_nxt;
  always_comb begin
    m_nxt = m_r;
    if (bus_wr && bus_be[0] && bus_addr == 3'h5) begin
      m_nxt = bus_wdata[0];
    end
    rc_nxt = bus_rd && bus_addr == 3'h0;
    rt_nxt = bus_rd && bus_addr == 3'h1;
    ri_nxt = bus_rd && bus_addr == 3'h4;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {m_r, rc_r, rt_r, ri_r} <= 4'h0;
    end else begin
      {m_r, rc_r, rt_r, ri_r} <= {m_nxt, rc_nxt, rt_nxt, ri_nxt};
    end
  end
  wire logic [4:0] c = bus_rdata[12:8];
  wire logic [4:0] d = bus_rdata[3] ? 5'h08 : 5'h10;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Assertions
  chk_empty_flag: assert property (rc_r |-> bus_rdata[6] == (c == 5'h00))
    else $error("empty flag wrong");
  chk_full_flag: assert property (rc_r |-> bus_rdata[7] == (c == d))
    else $error("full flag wrong");
  chk_depth_max: assert property (rc_r |-> c <= d)
    else $error("count above depth");
  chk_ctrl_pad: assert property (rc_r |-> bus_rdata[15:14] == 2'h0 && !bus_rdata[5])
    else $error("control pad bits set");
  chk_taps_low: assert property (rt_r |-> !bus_rdata[0])
    else $error("tap bit zero set");
  chk_irq_mask: assert property (irq |-> m_r)
    else $error("irq while masked");
  chk_irq_hold: assert property ($past(irq) && m_r && !ri_r |-> irq)
    else $error("irq dropped early");
  chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0)
    else $error("read data outside slot");
endmodule : pcf_crc_engine_checker
bind pcf_crc_engine pcf_crc_engine_checker pcf_crc_engine_checker_inst (.ref_clk(ref_clk),
  .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq));
`default_nettype wire

/* dv/pcf_crc_engine_tb.sv */
// Self-checking bench for the CRC engine
`timescale 1ns/1ps
`default_nettype none
module pcf_crc_engine_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, slp = 1'b0, idl = 1'b0;
  logic [2:0] a = 3'h0;
  logic [15:0] wd = 16'h0, rdata, crc, tp;
  logic [1:0] be = 2'h0;
  logic irq, pend = 1'b0;
  logic [15:0] q[$];
  logic [31:0] seed = 32'ha71df041;
  int errors = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  pcf_crc_engine pcf_crc_engine_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(a),
    .bus_wdata(wd), .bus_be(be), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata),
    .sleep_mode(slp), .idle_mode(idl), .irq(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Msb first, feedback into bit zero and every enabled tap
  function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] w,
      input logic [3:0] l, input logic [15:0] t);
    logic [15:0] m;
    logic f;
    m = 16'hffff >> (4'hf - l);
    for (int b = 15; b >= 0; b--) begin
      if (b <= l) begin
        f = w[b] ^ c[l];
        c = (c << 1) & m;
        c = f ? c ^ ({t[15:1], 1'b1} & m) : c;
      end
    end
    return c;
  endfunction : step
  function automatic logic [15:0] cv(input logic s, input logic [4:0] n, input logic g,
      input logic [3:0] l);
    return {2'h0, s, n, n == (l > 4'h7 ? 5'h08 : 5'h10), n == 5'h00, 1'b0, g, l};
  endfunction : cv
  task automatic wrr(input logic [2:0] ad, input logic [15:0] d, input logic [1:0] b);
    @(posedge ref_clk);
    {a, wd, be, wr} <= {ad, d, b, 1'b1};
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [2:0] ad, input logic [15:0] e);
    @(posedge ref_clk);
    {a, rd} <= {ad, 1'b1};
    q.push_back(e);
    @(posedge ref_clk);
    rd <= 1'b0;
  endtask : rdr
  task automatic cmp_rd(input logic [15:0] e);
    checked++;
    if (rdata !== e) begin
      errors++;
      $display("[FAIL] %0t read %h wanted %h", $time, rdata, e);
    end
  endtask : cmp_rd
  task automatic cmp_irq(input logic e);
    checked++;
    if (irq !== e) begin
      errors++;
      $display("[FAIL] %0t irq %b", $time, irq);
    end
  endtask : cmp_irq
  task automatic end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  // Read data stands in the cycle after the strobe only
  always @(posedge ref_clk) begin
    if (pend) begin
      cmp_rd(q.pop_front());
    end
    pend = rd;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdr(3'h0, 16'h0040);
    for (int i = 1; i < 8; i++) begin
      rdr(i[2:0], 16'h0);
    end
    $display("test reset done");
    wrr(3'h1, 16'h1020, 2'h3);
    wrr(3'h0, 16'h000f, 2'h3);
    wrr(3'h5, 16'h0001, 2'h3);
    crc = 16'h0;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      wrr(3'h3, seed[15:0], 2'h3);
      crc = step(crc, seed[15:0], 4'hf, 16'h1020);
    end
    rdr(3'h0, cv(1'b0, 5'h03, 1'b0, 4'hf));
    wrr(3'h0, 16'h001f, 2'h3);
    repeat (47) @(posedge ref_clk);
    #1 cmp_irq(1'b0);
    @(posedge ref_clk);
    #1 cmp_irq(1'b1);
    rdr(3'h3, crc);
    rdr(3'h4, 16'h0001);
    #1 cmp_irq(1'b0);
    $display("test crc done");
    // Upper byte completes a 9+ bit word, lower byte alone only stages
    wrr(3'h0, 16'h000b, 2'h3);
    wrr(3'h3, 16'h00ff, 2'h1);
    rdr(3'h0, cv(1'b0, 5'h00, 1'b0, 4'hb));
    wrr(3'h3, 16'hff00, 2'h2);
    rdr(3'h0, cv(1'b0, 5'h01, 1'b0, 4'hb));
    wrr(3'h0, 16'h0007, 2'h3);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      wrr(3'h3, seed[15:0], 2'h1);
      if (i == 14) rdr(3'h0, cv(1'b0, 5'h10, 1'b0, 4'h7));
    end
    rdr(3'h0, cv(1'b0, 5'h00, 1'b0, 4'h7));
    rdr(3'h4, 16'h0000);
    wrr(3'h0, 16'h000f, 2'h3);
    for (int i = 0; i < 8; i++) wrr(3'h3, 16'h1234, 2'h3);
    rdr(3'h0, cv(1'b0, 5'h08, 1'b0, 4'hf));
    wrr(3'h0, 16'h001f, 2'h3);
    repeat (130) @(posedge ref_clk);
    rdr(3'h0, cv(1'b0, 5'h00, 1'b1, 4'hf));
    rdr(3'h4, 16'h0001);
    $display("test fifo done");
    // Sleep mid-word; a push while frozen is dropped
    wrr(3'h0, 16'h0007, 2'h3);
    // Random seed in the result register starts the sum
    seed = xs(seed);
    crc = seed[15:0];
    wrr(3'h2, crc, 2'h3);
    seed = xs(seed);
    tp = seed[15:0];
    wrr(3'h1, tp, 2'h3);
    rdr(3'h1, tp & 16'hfffe);
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      wrr(3'h3, seed[15:0], 2'h1);
      crc = step(crc, seed[15:0], 4'h7, tp);
    end
    wrr(3'h0, 16'h0017, 2'h3);
    repeat (5) @(posedge ref_clk);
    slp <= 1'b1;
    wrr(3'h3, 16'h00aa, 2'h1);
    repeat (40) @(posedge ref_clk);
    rdr(3'h0, cv(1'b0, 5'h02, 1'b1, 4'h7));
    slp <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rdr(3'h2, crc);
    idl <= 1'b1;
    wrr(3'h3, 16'h0055, 2'h1);
    repeat (12) @(posedge ref_clk);
    rdr(3'h0, cv(1'b0, 5'h00, 1'b1, 4'h7));
    wrr(3'h0, 16'h2017, 2'h3);
    wrr(3'h3, 16'h0055, 2'h1);
    rdr(3'h0, cv(1'b1, 5'h00, 1'b1, 4'h7));
    #1 cmp_irq(1'b1);
    $display("test power done");
    repeat (2) @(posedge ref_clk);
    end_sim();
  end
endmodule : pcf_crc_engine_tb
`default_nettype wire
